// File: logic/elin_cfg.svh
// Register map, field positions and constants of the link check block
`ifndef ELIN_CFG_SVH
`define ELIN_CFG_SVH
`define ELIN_AW 12
`define ELIN_A_CTRL 12'h000
`define ELIN_A_CHECK 12'h004
`define ELIN_A_KEYVEC 12'h008
`define ELIN_A_FLAGS 12'h00C
`define ELIN_A_IRQ_STAT 12'h010
`define ELIN_A_IRQ_CLR 12'h014
`define ELIN_A_IRQ_EN 12'h018
`define ELIN_B_ENC 0
`define ELIN_B_MASK_V 1
`define ELIN_B_MASK_A 2
`define ELIN_B_SRST 3
`define ELIN_B_START 4
`define ELIN_B_PINB_SEL 5
`define ELIN_B_PINA_SEL 6
`define ELIN_F_AUTH 0
`define ELIN_F_NEWDEV 1
`define ELIN_I_CHK 0
`define ELIN_I_AUTH 1
`define ELIN_I_NEWDEV 2
`define ELIN_IRQ_W 3
`define ELIN_HSIZE_WORD 3'h2
`define ELIN_RESP_OKAY 1'h0
`define ELIN_FRAME_CNT_W 4
// Sixteen sync periods per check value
`define ELIN_FRAME_LAST 4'hF
`define ELIN_CHK_W 8
`define ELIN_CHK_RST 8'h00
`define ELIN_KS_W 32
`define ELIN_FOLD_N 4
`define ELIN_LFSR_SEED 32'h1D87_2B41
`define ELIN_LFSR_TAPS 32'h8020_0003
`define ELIN_VID_W 24
`define ELIN_AUD_W 8
`endif

// File: logic/elin_pkg.sv
// Types shared by the link check block
`default_nettype none
`include "elin_cfg.svh"
package elin_pkg;
  typedef struct packed {
    logic [`ELIN_VID_W-1:0] vid;
    logic [`ELIN_AUD_W-1:0] aud;
  } elin_av_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`ELIN_AW-1:0] addr;
  } elin_aphase_s;
  typedef logic [`ELIN_CHK_W-1:0] elin_chk_t;
endpackage
`default_nettype wire

// File: logic/elin_frame_cnt.sv
// Sync period counter giving one tick per check interval
`timescale 1ns/1ps
`default_nettype none
`include "elin_cfg.svh"
module elin_frame_cnt (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic vsync_i,
  output logic tick_o
);
  logic vs_r;
  logic rise;
  logic [`ELIN_FRAME_CNT_W-1:0] cnt_r;

  assign rise = vsync_i & ~vs_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vs_r <= 1'b0;
    end else if (ce_i) begin
      vs_r <= vsync_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (ce_i) begin
      if (clr_i || !en_i) begin
        cnt_r <= '0;
      end else if (rise) begin
        cnt_r <= cnt_r + `ELIN_FRAME_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else if (ce_i) begin
      // see RULE1
      tick_o <= en_i & ~clr_i & rise & (cnt_r == `ELIN_FRAME_LAST);
    end
  end

  a_tick_on_last: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE1
    ce_i && en_i && !clr_i && rise && cnt_r == `ELIN_FRAME_LAST |=> tick_o)
    else $error("check tick missing after sixteenth sync");

  a_tick_needs_en: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE1
    $rose(tick_o) |-> $past(en_i) && $past(cnt_r) == `ELIN_FRAME_LAST)
    else $error("check tick without encryption or early");
endmodule
`default_nettype wire

// File: logic/elin_ks_gen.sv
// Keystream source and per-interval check accumulator
`timescale 1ns/1ps
`default_nettype none
`include "elin_cfg.svh"
module elin_ks_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic load_i,
  output logic [`ELIN_KS_W-1:0] ks_o,
  output logic [`ELIN_CHK_W-1:0] acc_o
);
  logic [`ELIN_KS_W-1:0] lfsr_r;
  logic [`ELIN_CHK_W-1:0] fold;

  // Stand-in keystream; the real cipher plugs in here
  genvar i;
  generate
    for (i = 0; i < `ELIN_CHK_W; i++) begin : g_fold
      assign fold[i] = ^lfsr_r[i*`ELIN_FOLD_N +: `ELIN_FOLD_N];
    end
  endgenerate

  assign ks_o = lfsr_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lfsr_r <= `ELIN_LFSR_SEED;
    end else if (ce_i) begin
      if (clr_i) begin
        lfsr_r <= `ELIN_LFSR_SEED;
      end else if (en_i) begin
        lfsr_r <= {lfsr_r[`ELIN_KS_W-2:0], 1'b0} ^
                  (lfsr_r[`ELIN_KS_W-1] ? `ELIN_LFSR_TAPS : '0);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_o <= `ELIN_CHK_RST;
    end else if (ce_i) begin
      if (clr_i) begin
        acc_o <= `ELIN_CHK_RST;
      end else if (load_i) begin
        acc_o <= fold;
      end else if (en_i) begin
        acc_o <= {acc_o[`ELIN_CHK_W-2:0], acc_o[`ELIN_CHK_W-1]} ^ fold;
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/elin_top.sv
// Link check, data masking and repeater notification with AHB-Lite regs
`timescale 1ns/1ps
`default_nettype none
`include "elin_cfg.svh"
// Behaviour
// RULE1: While encryption runs, a fresh check value is loaded every 16 syncs.
// RULE2: Making the check value never stalls the audio and video path.
// RULE3: Software reads both check values once every 16 frames.
// RULE4: Equal values pass and software waits for the next interval.
// RULE5: Software retries twice more and fails after three mismatches.
// RULE6: After a failure the mask bits blank the audio and video inputs.
// RULE7: Software then writes 0 to the encryption enable at both ends.
// RULE8: With encryption off the block sends the plain data unencrypted.
// RULE9: Software restarts with the soft reset, then the start bit.
// RULE10: A downstream controller may set the new device flag.
// RULE11: A repeater waits for an upstream request before authenticating.
// RULE12: A key vector write sets the auth flag and, if selected, pin B.
// RULE13: The repeater controller acts on a rise of that flag or pin.
// RULE14: The repeater controller clears the auth flag afterwards.
// RULE15: With its select set, pin A follows the encryption enable bit.
// RULE16: The check value register changes whole, on the sync boundary.
module elin_top (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic VSYNC_I,
  input wire logic DE_I,
  input wire elin_pkg::elin_av_s AV_I,
  output elin_pkg::elin_av_s AV_O,
  output logic DE_O,
  output logic VSYNC_O,
  output logic AUX_PIN_A_O,
  output logic AUX_PIN_B_O,
  output logic START_AUTH_O,
  output logic IRQ_O
);
  elin_pkg::elin_aphase_s ap_r;
  elin_pkg::elin_aphase_s ap_nxt;
  elin_pkg::elin_chk_t check_r;
  elin_pkg::elin_chk_t acc;
  elin_pkg::elin_av_s masked;
  logic [`ELIN_KS_W-1:0] ks;
  logic [31:0] key_r;
  logic [31:0] rd_mux;
  logic [`ELIN_IRQ_W-1:0] irq_stat_r;
  logic [`ELIN_IRQ_W-1:0] irq_en_r;
  logic [`ELIN_IRQ_W-1:0] irq_ev;
  logic [`ELIN_IRQ_W-1:0] irq_clr;
  logic enc_r;
  logic mask_v_r;
  logic mask_audio_input_r;
  logic sel_a_r;
  logic sel_b_r;
  logic auth_begun_flag_r;
  logic new_device_flag_r;
  logic tick;
  logic wr_ctrl;
  logic wr_key;
  logic wr_flags;
  logic wr_word;
  logic srst;

  // Address phase capture
  always_comb begin
    ap_nxt = '0;
    if (HSEL_I && HTRANS_I[1] && HREADY_I) begin
      ap_nxt.wr = HWRITE_I && (HSIZE_I == `ELIN_HSIZE_WORD);
      ap_nxt.rd = !HWRITE_I;
      ap_nxt.addr = HADDR_I[`ELIN_AW-1:0];
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ap_r <= '0;
    end else if (CE_I) begin
      ap_r <= ap_nxt;
    end
  end

  // Zero wait states, so the slave never holds the bus
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= `ELIN_RESP_OKAY;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= `ELIN_RESP_OKAY;
    end
  end

  assign wr_word = CE_I && ap_r.wr;
  assign wr_ctrl = wr_word && ap_r.addr == `ELIN_A_CTRL;
  assign wr_key = wr_word && ap_r.addr == `ELIN_A_KEYVEC;
  assign wr_flags = wr_word && ap_r.addr == `ELIN_A_FLAGS;
  assign srst = wr_ctrl && HWDATA_I[`ELIN_B_SRST];

  // Read data is taken in the address phase; whole word, never torn
  always_comb begin
    rd_mux = '0;
    unique case (HADDR_I[`ELIN_AW-1:0])
      `ELIN_A_CTRL: begin
        rd_mux[`ELIN_B_ENC] = enc_r;
        rd_mux[`ELIN_B_MASK_V] = mask_v_r;
        rd_mux[`ELIN_B_MASK_A] = mask_audio_input_r;
        rd_mux[`ELIN_B_PINB_SEL] = sel_b_r;
        rd_mux[`ELIN_B_PINA_SEL] = sel_a_r;
      end
      `ELIN_A_CHECK: rd_mux[`ELIN_CHK_W-1:0] = check_r; // see RULE16
      `ELIN_A_KEYVEC: rd_mux = key_r;
      `ELIN_A_FLAGS: begin
        rd_mux[`ELIN_F_AUTH] = auth_begun_flag_r;
        rd_mux[`ELIN_F_NEWDEV] = new_device_flag_r;
      end
      `ELIN_A_IRQ_STAT: rd_mux[`ELIN_IRQ_W-1:0] = irq_stat_r;
      `ELIN_A_IRQ_EN: rd_mux[`ELIN_IRQ_W-1:0] = irq_en_r;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      HRDATA_O <= '0;
    end else if (CE_I && ap_nxt.rd) begin
      HRDATA_O <= rd_mux;
    end
  end

  // Control register; soft reset overrides a same-write enable
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      enc_r <= 1'b0;
      mask_v_r <= 1'b0;
      mask_audio_input_r <= 1'b0;
      sel_a_r <= 1'b0;
      sel_b_r <= 1'b0;
    end else if (wr_ctrl) begin
      enc_r <= HWDATA_I[`ELIN_B_ENC] & ~HWDATA_I[`ELIN_B_SRST];
      mask_v_r <= HWDATA_I[`ELIN_B_MASK_V];
      mask_audio_input_r <= HWDATA_I[`ELIN_B_MASK_A];
      sel_a_r <= HWDATA_I[`ELIN_B_PINA_SEL];
      sel_b_r <= HWDATA_I[`ELIN_B_PINB_SEL];
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      START_AUTH_O <= 1'b0;
    end else if (CE_I) begin
      START_AUTH_O <= wr_ctrl && HWDATA_I[`ELIN_B_START];
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      key_r <= '0;
    end else if (wr_key) begin
      key_r <= HWDATA_I;
    end
  end

  // Key write sets the flag; set beats a same-cycle clear
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      auth_begun_flag_r <= 1'b0;
    end else if (CE_I) begin
      if (wr_key) begin
        auth_begun_flag_r <= 1'b1; // see RULE12
      end else if (srst ||
                   (wr_flags && HWDATA_I[`ELIN_F_AUTH])) begin
        auth_begun_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      new_device_flag_r <= 1'b0;
    end else if (wr_flags) begin
      new_device_flag_r <= HWDATA_I[`ELIN_F_NEWDEV];
    end
  end

  elin_frame_cnt u_frame (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .clr_i(srst),
    .en_i(enc_r),
    .vsync_i(VSYNC_I),
    .tick_o(tick)
  );

  elin_ks_gen u_ks (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .clr_i(srst),
    .en_i(enc_r),
    .load_i(tick),
    .ks_o(ks),
    .acc_o(acc)
  );

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      check_r <= `ELIN_CHK_RST;
    end else if (CE_I) begin
      if (srst) begin
        check_r <= `ELIN_CHK_RST;
      end else if (tick) begin
        check_r <= acc; // see RULE1, see RULE16
      end
    end
  end

  // Data path runs every enabled cycle, check logic only taps the stream
  always_comb begin
    masked = AV_I;
    if (mask_v_r) begin
      masked.vid = '0; // see RULE6
    end
    if (mask_audio_input_r) begin
      masked.aud = '0; // see RULE6
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      AV_O <= '0;
      DE_O <= 1'b0;
      VSYNC_O <= 1'b0;
    end else if (CE_I) begin
      // see RULE2, see RULE8
      AV_O <= enc_r ? (masked ^ ks) : masked;
      DE_O <= DE_I;
      VSYNC_O <= VSYNC_I;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      AUX_PIN_A_O <= 1'b0;
      AUX_PIN_B_O <= 1'b0;
    end else if (CE_I) begin
      AUX_PIN_A_O <= sel_a_r & enc_r; // see RULE15
      AUX_PIN_B_O <= sel_b_r & auth_begun_flag_r; // see RULE12
    end
  end

  // Interrupts: sticky, set wins over clear
  assign irq_ev[`ELIN_I_CHK] = CE_I && tick && !srst;
  assign irq_ev[`ELIN_I_AUTH] = wr_key && !auth_begun_flag_r;
  assign irq_ev[`ELIN_I_NEWDEV] = wr_flags && !new_device_flag_r &&
                                  HWDATA_I[`ELIN_F_NEWDEV];
  assign irq_clr = (wr_word && ap_r.addr == `ELIN_A_IRQ_CLR) ?
                   HWDATA_I[`ELIN_IRQ_W-1:0] : '0;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_stat_r <= '0;
    end else if (CE_I) begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_en_r <= '0;
    end else if (wr_word && ap_r.addr == `ELIN_A_IRQ_EN) begin
      irq_en_r <= HWDATA_I[`ELIN_IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      IRQ_O <= 1'b0;
    end else if (CE_I) begin
      IRQ_O <= |(irq_stat_r & irq_en_r);
    end
  end

  sequence s_key_write;
    wr_key && sel_b_r;
  endsequence

  sequence s_pin_b_up;
    CE_I ##1 AUX_PIN_B_O;
  endsequence

  a_chk_load_tick: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE1
    CE_I && tick && !srst |=> check_r == $past(acc))
    else $error("check value not loaded on interval tick");

  a_chk_hold_whole: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE16
    !(CE_I && (tick || srst)) |=> $stable(check_r))
    else $error("check value changed off the sync boundary");

  a_mask_blanks_av: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE6
    CE_I && !enc_r && mask_v_r && mask_audio_input_r |=> AV_O == '0)
    else $error("masked inputs reached the output");

  a_plain_pass_av: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE8
    !RST_I && CE_I && !enc_r && !mask_v_r && !mask_audio_input_r
    |=> AV_O == $past(AV_I))
    else $error("plain data altered with encryption off");

  a_path_no_stall: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE2
    !RST_I && CE_I ##1 CE_I
    |-> DE_O == $past(DE_I) && VSYNC_O == $past(VSYNC_I))
    else $error("data path stalled");

  a_auth_pin_b: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE12
    s_key_write ##1 (CE_I && sel_b_r && !srst && !wr_flags) |-> s_pin_b_up)
    else $error("pin B did not rise after key write");

  a_auth_flag_set: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE12
    wr_key |=> auth_begun_flag_r)
    else $error("auth flag not set by key write");

  a_pin_a_follow: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE15
    CE_I |=> AUX_PIN_A_O == $past(sel_a_r && enc_r))
    else $error("pin A does not follow encryption enable");
endmodule
`default_nettype wire

// File: sim/elin_host_model.sv
// Host controller model driving the register bus
`timescale 1ns/1ps
`default_nettype none
`include "elin_cfg.svh"
module elin_host_model (
  input wire logic clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0000_0000;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = `ELIN_HSIZE_WORD;
    hwdata_o = 32'h0000_0000;
  end
  // Single word transfer; no wait count assumed, the bench watchdog bounds it
  task automatic xfer(input logic wr, input logic [11:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge clk_i);
    hsel_o <= 1'b1;
    htrans_o <= 2'h2;
    hwrite_o <= wr;
    haddr_o <= {20'h0_0000, addr};
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    htrans_o <= 2'h0;
    hwdata_o <= wdata;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    rdata = hrdata_i;
  endtask
endmodule
`default_nettype wire

// File: sim/enhanced_link_integrity_notify_bench.sv
// Self-checking testbench of the link check block
`timescale 1ns/1ps
`default_nettype none
`include "elin_cfg.svh"
module enhanced_link_integrity_notify_bench;
  typedef struct {logic wr; logic [11:0] a; logic [31:0] d;} elin_row_s;
  logic clk, rst, ce, hsel, hwrite, hready, hresp, vsync, de;
  logic de_o, vsync_o, pin_a, pin_b, start, irq;
  logic [31:0] haddr, hwdata, hrdata, rd, chk_word;
  logic [1:0] htrans;
  logic [2:0] hsize;
  elin_pkg::elin_av_s av_i, av_o;
  int miscompares = 0;
  int num_checks = 0;
  int starts = 0;
  // Reads carry the expected word in d
  elin_row_s rows [18] = '{
    '{1'b0, `ELIN_A_CTRL, 32'h0000_0000},
    '{1'b0, `ELIN_A_CHECK, 32'h0000_0000},
    '{1'b0, `ELIN_A_IRQ_STAT, 32'h0000_0000},
    '{1'b1, `ELIN_A_CTRL, 32'h0000_0066},
    '{1'b0, `ELIN_A_CTRL, 32'h0000_0066},
    '{1'b1, 12'h01C, 32'hFFFF_FFFF},
    '{1'b0, 12'h01C, 32'h0000_0000},
    '{1'b1, `ELIN_A_IRQ_EN, 32'h0000_0007},
    '{1'b0, `ELIN_A_IRQ_EN, 32'h0000_0007},
    '{1'b1, `ELIN_A_KEYVEC, 32'hA5A5_5A5A},
    '{1'b0, `ELIN_A_KEYVEC, 32'hA5A5_5A5A},
    '{1'b0, `ELIN_A_FLAGS, 32'h0000_0001},
    '{1'b0, `ELIN_A_IRQ_STAT, 32'h0000_0002},
    '{1'b1, `ELIN_A_FLAGS, 32'h0000_0001},
    '{1'b0, `ELIN_A_FLAGS, 32'h0000_0000},
    '{1'b1, `ELIN_A_FLAGS, 32'h0000_0002},
    '{1'b0, `ELIN_A_IRQ_STAT, 32'h0000_0006},
    '{1'b1, `ELIN_A_IRQ_CLR, 32'h0000_0007}
  };

  elin_top dut (.CLK_I(clk), .RST_I(rst), .CE_I(ce), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .VSYNC_I(vsync), .DE_I(de),
    .AV_I(av_i), .AV_O(av_o), .DE_O(de_o), .VSYNC_O(vsync_o),
    .AUX_PIN_A_O(pin_a), .AUX_PIN_B_O(pin_b), .START_AUTH_O(start),
    .IRQ_O(irq));
  elin_host_model host (.clk_i(clk), .hready_i(hready), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
    .hsize_o(hsize), .hwdata_o(hwdata));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (start === 1'b1) starts <= starts + 1;

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: pin got %b want %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0000_0000, rd);
    chk32(rd, e);
  endtask
  // Sample at the falling edge so registered outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clk);
      vsync <= 1'b1;
      repeat (2) @(posedge clk);
      chk1(vsync_o, 1'b1);
      vsync <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #500000;
    miscompares++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    vsync = 1'b0;
    de = 1'b0;
    av_i = 32'h0000_0000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      else rdc(rows[i].a, rows[i].d);
    end
    $display("register table done");
    av_i <= 32'hABCD_EF12;
    de <= 1'b1;
    settle(2);
    chk32(av_o, 32'h0000_0000);
    chk1(de_o, 1'b1);
    wr(`ELIN_A_CTRL, 32'h0000_0060);
    settle(2);
    chk32(av_o, 32'hABCD_EF12);
    chk1(pin_a, 1'b0);
    wr(`ELIN_A_CTRL, 32'h0000_0062);
    settle(2);
    chk32(av_o, 32'h0000_0012);
    $display("masking done");
    wr(`ELIN_A_KEYVEC, 32'h1234_5678);
    settle(1);
    chk1(pin_b, 1'b1);
    chk1(irq, 1'b1);
    chk32(starts, 32'h0000_0000);
    wr(`ELIN_A_FLAGS, 32'h0000_0001);
    wr(`ELIN_A_IRQ_CLR, 32'h0000_0007);
    settle(1);
    chk1(pin_b, 1'b0);
    chk1(irq, 1'b0);
    wr(`ELIN_A_IRQ_EN, 32'h0000_0001);
    wr(`ELIN_A_KEYVEC, 32'h8765_4321);
    settle(1);
    chk1(irq, 1'b0);
    rdc(`ELIN_A_IRQ_STAT, 32'h0000_0002);
    wr(`ELIN_A_IRQ_CLR, 32'h0000_0007);
    $display("notify done");
    wr(`ELIN_A_CTRL, 32'h0000_0061);
    settle(1);
    chk1(pin_a, 1'b1);
    frames(15);
    rdc(`ELIN_A_IRQ_STAT, 32'h0000_0000);
    chk1(de_o, 1'b1);
    frames(1);
    rdc(`ELIN_A_IRQ_STAT, 32'h0000_0001);
    chk1(irq, 1'b1);
    wr(`ELIN_A_IRQ_CLR, 32'h0000_0001);
    frames(16);
    rdc(`ELIN_A_IRQ_STAT, 32'h0000_0001);
    host.xfer(1'b0, `ELIN_A_CHECK, 32'h0000_0000, chk_word);
    chk32(chk_word & 32'hFFFF_FF00, 32'h0000_0000);
    // Value stands all interval, so every retry sees the same word
    repeat (3) rdc(`ELIN_A_CHECK, chk_word);
    $display("check interval done");
    wr(`ELIN_A_CTRL, 32'h0000_0007);
    wr(`ELIN_A_CTRL, 32'h0000_0006);
    settle(2);
    chk32(av_o, 32'h0000_0000);
    wr(`ELIN_A_CTRL, 32'h0000_0008);
    rdc(`ELIN_A_CTRL, 32'h0000_0000);
    rdc(`ELIN_A_CHECK, 32'h0000_0000);
    wr(`ELIN_A_CTRL, 32'h0000_0010);
    settle(2);
    chk32(starts, 32'h0000_0001);
    $display("restart done");
    // Write while frozen must not land
    @(posedge clk);
    ce <= 1'b0;
    wr(`ELIN_A_IRQ_EN, 32'h0000_0007);
    ce <= 1'b1;
    rdc(`ELIN_A_IRQ_EN, 32'h0000_0001);
    $display("clock enable done");
    wr(`ELIN_A_IRQ_EN, 32'h0000_0007);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(`ELIN_A_IRQ_EN, 32'h0000_0000);
    chk1(hresp, 1'b0);
    $display("reset done");
    summarize();
  end
endmodule
`default_nettype wire
